/* File: rtl/ppc_top.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module ppc_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic [7:0]  first_port_data_in,
	output logic      [7:0]  first_port_data_out,
	output logic      [7:0]  first_port_data_oe,
	input  wire logic [7:0]  second_port_data_in,
	output logic      [7:0]  second_port_data_out,
	output logic      [7:0]  second_port_data_oe,
	input  wire logic        first_port_edge_line,
	input  wire logic        second_port_edge_line,
	input  wire logic        first_port_control_line_in,
	output logic             first_port_control_line_out,
	output logic             first_port_control_line_oe,
	input  wire logic        second_port_control_line_in,
	output logic             second_port_control_line_out,
	output logic             second_port_control_line_oe,
	output logic      [1:0]  ext_bank_sel,
	output logic             cpu_ext_access,
	output logic             video_ext_access,
	output logic             selftest_map,
	output logic             irq
);

	typedef struct packed {
		logic [7:0] ddr_a;
		logic [7:0] out_a;
		logic [7:0] ddr_b;
		logic [7:0] out_b;
		logic [5:0] ctl_a;
		logic [5:0] ctl_b;
		logic [3:0] irq_en;
		logic [7:0] rdata;
		logic [4:0] mem;
	} ppc_regs_t;

	ppc_regs_t r_q;
	ppc_regs_t r_d;

	logic [7:0] pins_a;
	logic [7:0] pins_b;
	logic [1:0] edge_s;
	logic [1:0] line_s;
	logic [3:0] flags;
	logic [3:0] src_en;
	logic [3:0] clr;
	logic [7:0] eff_b;
	logic       acc_a;
	logic       acc_b;
	logic       rd_io_a;
	logic       rd_io_b;
	logic       clr_wr;

	ppc_sync #(.W(8)) u_sync_a (
		.clk   (clk),
		.reset (reset),
		.din   (first_port_data_in),
		.dout  (pins_a)
	);

	ppc_sync #(.W(8)) u_sync_b (
		.clk   (clk),
		.reset (reset),
		.din   (second_port_data_in),
		.dout  (pins_b)
	);

	ppc_sync #(.W(4)) u_sync_ctl (
		.clk   (clk),
		.reset (reset),
		.din   ({second_port_control_line_in, first_port_control_line_in,
			second_port_edge_line, first_port_edge_line}),
		.dout  ({line_s, edge_s})
	);

	assign rd_io_a = rd && addr == ppc_pkg::ADDR_FIRST_DATA && r_q.ctl_a[ppc_pkg::CTL_IO_SEL];
	assign rd_io_b = rd && addr == ppc_pkg::ADDR_SECOND_DATA && r_q.ctl_b[ppc_pkg::CTL_IO_SEL];
	assign acc_a   = rd_io_a;
	assign acc_b   = wr && addr == ppc_pkg::ADDR_SECOND_DATA && r_q.ctl_b[ppc_pkg::CTL_IO_SEL];
	assign clr_wr  = wr && addr == ppc_pkg::ADDR_IRQ_CLEAR;

	// Reading a port's input register clears both of its flags.
	always_comb begin
		clr = clr_wr ? wdata[3:0] : 4'h0;
		if (rd_io_a) begin
			clr[ppc_pkg::IRQ_FIRST_EDGE] = 1'b1;
			clr[ppc_pkg::IRQ_FIRST_LINE] = 1'b1;
		end
		if (rd_io_b) begin
			clr[ppc_pkg::IRQ_SECOND_EDGE] = 1'b1;
			clr[ppc_pkg::IRQ_SECOND_LINE] = 1'b1;
		end
	end

	ppc_ctl_line u_line_a (
		.clk        (clk),
		.reset      (reset),
		.ctl        (r_q.ctl_a),
		.edge_line  (edge_s[0]),
		.line_in    (line_s[0]),
		.access     (acc_a),
		.clear_edge (clr[ppc_pkg::IRQ_FIRST_EDGE]),
		.clear_line (clr[ppc_pkg::IRQ_FIRST_LINE]),
		.edge_flag  (flags[ppc_pkg::IRQ_FIRST_EDGE]),
		.line_flag  (flags[ppc_pkg::IRQ_FIRST_LINE]),
		.line_out   (first_port_control_line_out),
		.line_oe    (first_port_control_line_oe)
	);

	ppc_ctl_line u_line_b (
		.clk        (clk),
		.reset      (reset),
		.ctl        (r_q.ctl_b),
		.edge_line  (edge_s[1]),
		.line_in    (line_s[1]),
		.access     (acc_b),
		.clear_edge (clr[ppc_pkg::IRQ_SECOND_EDGE]),
		.clear_line (clr[ppc_pkg::IRQ_SECOND_LINE]),
		.edge_flag  (flags[ppc_pkg::IRQ_SECOND_EDGE]),
		.line_flag  (flags[ppc_pkg::IRQ_SECOND_LINE]),
		.line_out   (second_port_control_line_out),
		.line_oe    (second_port_control_line_oe)
	);

	// Undriven port B bits read as pulled high, as the memory selects see them.
	assign eff_b = (r_q.out_b & r_q.ddr_b) | ~r_q.ddr_b;

	always_comb begin
		r_d       = r_q;
		r_d.rdata = ppc_pkg::READ_UNMAPPED;
		if (wr) begin
			if (addr == ppc_pkg::ADDR_FIRST_DATA) begin
				if (r_q.ctl_a[ppc_pkg::CTL_IO_SEL]) begin
					r_d.out_a = wdata;
				end else begin
					r_d.ddr_a = wdata;
				end
			end else if (addr == ppc_pkg::ADDR_SECOND_DATA) begin
				if (r_q.ctl_b[ppc_pkg::CTL_IO_SEL]) begin
					r_d.out_b = wdata;
				end else begin
					r_d.ddr_b = wdata;
				end
			end else if (addr == ppc_pkg::ADDR_FIRST_CTL) begin
				r_d.ctl_a = wdata[5:0];
			end else if (addr == ppc_pkg::ADDR_SECOND_CTL) begin
				r_d.ctl_b = wdata[5:0];
			end else if (addr == ppc_pkg::ADDR_IRQ_ENABLE) begin
				r_d.irq_en = wdata[3:0];
			end
		end
		if (rd) begin
			if (addr == ppc_pkg::ADDR_FIRST_DATA) begin
				r_d.rdata = r_q.ctl_a[ppc_pkg::CTL_IO_SEL] ? pins_a : r_q.ddr_a;
			end else if (addr == ppc_pkg::ADDR_SECOND_DATA) begin
				r_d.rdata = r_q.ctl_b[ppc_pkg::CTL_IO_SEL] ? pins_b : r_q.ddr_b;
			end else if (addr == ppc_pkg::ADDR_FIRST_CTL) begin
				r_d.rdata = {flags[ppc_pkg::IRQ_FIRST_EDGE], flags[ppc_pkg::IRQ_FIRST_LINE],
					r_q.ctl_a};
			end else if (addr == ppc_pkg::ADDR_SECOND_CTL) begin
				r_d.rdata = {flags[ppc_pkg::IRQ_SECOND_EDGE], flags[ppc_pkg::IRQ_SECOND_LINE],
					r_q.ctl_b};
			end else if (addr == ppc_pkg::ADDR_IRQ_STATUS) begin
				r_d.rdata = {4'h0, flags};
			end else if (addr == ppc_pkg::ADDR_IRQ_ENABLE) begin
				r_d.rdata = {4'h0, r_q.irq_en};
			end
		end
		r_d.mem[1:0] = eff_b[ppc_pkg::BANK_HI:ppc_pkg::BANK_LO];
		r_d.mem[2]   = ~eff_b[ppc_pkg::CPU_PRIMARY];
		r_d.mem[3]   = ~eff_b[ppc_pkg::VID_PRIMARY];
		r_d.mem[4]   = ~eff_b[ppc_pkg::SELFTEST_OFF] & eff_b[ppc_pkg::KERNEL_ON];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_q <= '{ppc_pkg::RST_DDR, ppc_pkg::RST_OUT, ppc_pkg::RST_DDR,
				ppc_pkg::RST_OUT, ppc_pkg::RST_CTL, ppc_pkg::RST_CTL,
				ppc_pkg::RST_IRQ_EN, 8'h00, 5'h00};
		end else begin
			r_q <= r_d;
		end
	end

	// Each flag reaches the request only with its own control enable and its mask bit.
	always_comb begin
		src_en = 4'h0;
		src_en[ppc_pkg::IRQ_FIRST_EDGE]  = r_q.ctl_a[ppc_pkg::CTL_EDGE_EN];
		src_en[ppc_pkg::IRQ_SECOND_EDGE] = r_q.ctl_b[ppc_pkg::CTL_EDGE_EN];
		src_en[ppc_pkg::IRQ_FIRST_LINE]  = ~r_q.ctl_a[ppc_pkg::CTL_LINE_OUT]
			& r_q.ctl_a[ppc_pkg::CTL_LINE_EN];
		src_en[ppc_pkg::IRQ_SECOND_LINE] = ~r_q.ctl_b[ppc_pkg::CTL_LINE_OUT]
			& r_q.ctl_b[ppc_pkg::CTL_LINE_EN];
	end

	assign irq = |(flags & src_en & r_q.irq_en);

	assign rdata                = r_q.rdata;
	assign first_port_data_out  = r_q.out_a;
	assign first_port_data_oe   = r_q.ddr_a;
	assign second_port_data_out = r_q.out_b;
	assign second_port_data_oe  = r_q.ddr_b;
	assign ext_bank_sel         = r_q.mem[1:0];
	assign cpu_ext_access       = r_q.mem[2];
	assign video_ext_access     = r_q.mem[3];
	assign selftest_map         = r_q.mem[4];

endmodule

/* File: shared/ppc_pkg.sv */
// Summary of operation
// - Port B output bits 3:2 pick one of four extended 16K windows, 00 lowest.
// - Port B bit 4 (processor) and bit 5 (video) pick extended bank when zero.
// - Port B bit 7 zero with kernel ROM on maps self-test ROM at 5000-57FF.
// - Control bits 7 and 6 read the two pending interrupt flags, read only.
// - Control field codes 000-011 make the control line an edge-flagged input.
// - Code 100 drives the control line low from data access (port A read, port B write) until the edge line's flagging edge.
// - Code 101 pulses the control line low one cycle after each port A data read or port B data write.
// - Code 110 drives the control line low, code 111 drives it high.
// - Control bit 2 steers data location: zero direction register, one input/output.
// - Control bit 1 picks the edge line's flagging edge: zero falling, one rising.
// - Control bit 0 enables the interrupt request from the edge line flag.
// - Reset clears each port's direction and output registers to zero.
// - Input/output read returns pin levels, write loads the output register.
package ppc_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	localparam logic [15:0] ADDR_FIRST_DATA  = 16'hd300;
	localparam logic [15:0] ADDR_SECOND_DATA = 16'hd301;
	localparam logic [15:0] ADDR_FIRST_CTL   = 16'hd302;
	localparam logic [15:0] ADDR_SECOND_CTL  = 16'hd303;
	localparam logic [15:0] ADDR_IRQ_STATUS  = 16'hd304;
	localparam logic [15:0] ADDR_IRQ_CLEAR   = 16'hd305;
	localparam logic [15:0] ADDR_IRQ_ENABLE  = 16'hd306;

	localparam logic [7:0] RST_DDR     = 8'h00;
	localparam logic [7:0] RST_OUT     = 8'h00;
	localparam logic [5:0] RST_CTL     = 6'h00;
	localparam logic [3:0] RST_IRQ_EN  = 4'h0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	localparam int CTL_EDGE_EN    = 0;
	localparam int CTL_EDGE_RISE  = 1;
	localparam int CTL_IO_SEL     = 2;
	localparam int CTL_LINE_EN    = 3;
	localparam int CTL_LINE_RISE  = 4;
	localparam int CTL_LINE_OUT   = 5;
	localparam int CTL_EDGE_FLAG  = 7;
	localparam int CTL_LINE_FLAG  = 6;

	localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
	localparam logic [2:0] MODE_PULSE     = 3'h5;
	localparam logic [2:0] MODE_LOW       = 3'h6;
	localparam logic [2:0] MODE_HIGH      = 3'h7;

	localparam int BANK_LO      = 2;
	localparam int BANK_HI      = 3;
	localparam int CPU_PRIMARY  = 4;
	localparam int VID_PRIMARY  = 5;
	localparam int SELFTEST_OFF = 7;
	localparam int KERNEL_ON    = 0;

	localparam int IRQ_FIRST_EDGE  = 0;
	localparam int IRQ_FIRST_LINE  = 1;
	localparam int IRQ_SECOND_EDGE = 2;
	localparam int IRQ_SECOND_LINE = 3;

	typedef enum logic [1:0] {
		LN_IDLE  = 2'h0,
		LN_PULSE = 2'h1,
		LN_HOLD  = 2'h2
	} ppc_line_st_t;

endpackage

/* File: rtl/ppc_sync.sv */
`timescale 1ns/100ps
module ppc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} ppc_sync_st_t;

	ppc_sync_st_t st_q;
	ppc_sync_st_t st_d;

	// A bit changes only once the second and third stages agree.
	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.val[i] = st_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.val;

endmodule

/* File: rtl/ppc_ctl_line.sv */
`timescale 1ns/100ps
module ppc_ctl_line (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [5:0] ctl,
	input  wire logic       edge_line,
	input  wire logic       line_in,
	input  wire logic       access,
	input  wire logic       clear_edge,
	input  wire logic       clear_line,
	output logic            edge_flag,
	output logic            line_flag,
	output logic            line_out,
	output logic            line_oe
);

	typedef struct packed {
		logic                  edge_prev;
		logic                  line_prev;
		logic                  edge_flag;
		logic                  line_flag;
		ppc_pkg::ppc_line_st_t st;
		logic                  lout;
	} ppc_line_q_t;

	ppc_line_q_t q;
	ppc_line_q_t d;
	logic        edge_hit;
	logic        line_hit;
	logic [2:0]  mode;

	always_comb begin
		d           = q;
		mode        = ctl[ppc_pkg::CTL_LINE_OUT:ppc_pkg::CTL_LINE_EN];
		d.edge_prev = edge_line;
		d.line_prev = line_in;
		edge_hit    = ctl[ppc_pkg::CTL_EDGE_RISE] ? (edge_line & ~q.edge_prev)
			: (~edge_line & q.edge_prev);
		line_hit    = ctl[ppc_pkg::CTL_LINE_RISE] ? (line_in & ~q.line_prev)
			: (~line_in & q.line_prev);
		// Flags clear first so that a same-cycle event still sets them.
		if (clear_edge) begin
			d.edge_flag = 1'b0;
		end
		if (clear_line) begin
			d.line_flag = 1'b0;
		end
		if (edge_hit) begin
			d.edge_flag = 1'b1;
		end
		if (!ctl[ppc_pkg::CTL_LINE_OUT] && line_hit) begin
			d.line_flag = 1'b1;
		end
		case (mode)
			ppc_pkg::MODE_HANDSHAKE: begin
				if (access) begin
					d.st = ppc_pkg::LN_HOLD;
				end else if (q.st == ppc_pkg::LN_HOLD && edge_hit) begin
					d.st = ppc_pkg::LN_IDLE;
				end else if (q.st == ppc_pkg::LN_PULSE) begin
					d.st = ppc_pkg::LN_IDLE;
				end
			end
			ppc_pkg::MODE_PULSE: begin
				d.st = access ? ppc_pkg::LN_PULSE : ppc_pkg::LN_IDLE;
			end
			default: begin
				d.st = ppc_pkg::LN_IDLE;
			end
		endcase
		case (mode)
			ppc_pkg::MODE_LOW:  d.lout = 1'b0;
			ppc_pkg::MODE_HIGH: d.lout = 1'b1;
			ppc_pkg::MODE_HANDSHAKE,
			ppc_pkg::MODE_PULSE: d.lout = (d.st == ppc_pkg::LN_IDLE);
			default:            d.lout = 1'b1;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '{1'b0, 1'b0, 1'b0, 1'b0, ppc_pkg::LN_IDLE, 1'b1};
		end else begin
			q <= d;
		end
	end

	assign edge_flag = q.edge_flag;
	assign line_flag = q.line_flag;
	assign line_out  = q.lout;
	assign line_oe   = ctl[ppc_pkg::CTL_LINE_OUT];

endmodule

/* File: testbench/ppc_far.sv */
`timescale 1ns/100ps
module ppc_far (
	input  wire logic [7:0] a_out,
	input  wire logic [7:0] a_oe,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe,
	input  wire logic       ca_out,
	input  wire logic       ca_oe,
	input  wire logic       cb_out,
	input  wire logic       cb_oe,
	input  wire logic [7:0] a_drv,
	input  wire logic [7:0] b_drv,
	input  wire logic       ca_drv,
	input  wire logic       cb_drv,
	output logic      [7:0] a_pin,
	output logic      [7:0] b_pin,
	output logic            ca_pin,
	output logic            cb_pin
);
	// The far side drives only the pins that the block leaves undriven.
	assign a_pin  = (a_out & a_oe) | (a_drv & ~a_oe);
	assign b_pin  = (b_out & b_oe) | (b_drv & ~b_oe);
	assign ca_pin = ca_oe ? ca_out : ca_drv;
	assign cb_pin = cb_oe ? cb_out : cb_drv;
endmodule

/* File: testbench/ppc_chk.sv */
`timescale 1ns/100ps
module ppc_chk (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [7:0]  rdata,
	input  wire logic [7:0]  second_port_data_out,
	input  wire logic [7:0]  second_port_data_oe,
	input  wire logic        second_port_control_line_out,
	input  wire logic        second_port_control_line_oe,
	input  wire logic [1:0]  ext_bank_sel,
	input  wire logic        cpu_ext_access,
	input  wire logic        video_ext_access,
	input  wire logic        selftest_map
);
	logic [5:0] ctl_q;
	logic [5:0] ctl_d;
	logic [7:0] eff;
	assign eff = second_port_data_out | ~second_port_data_oe;
	always_comb begin
		ctl_d = ctl_q;
		if (wr && addr == ppc_pkg::ADDR_SECOND_CTL) begin
			ctl_d = wdata[5:0];
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_q <= 6'h00;
		end else begin
			ctl_q <= ctl_d;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_acc(logic [3:0] m);
		wr && addr == ppc_pkg::ADDR_SECOND_DATA && ctl_q[5:2] == m;
	endsequence
	property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_bank; !$past(reset) |-> ext_bank_sel == $past(eff[3:2]); endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	property p_cpu; !$past(reset) |-> cpu_ext_access == !$past(eff[4]); endproperty
	a_cpu: assert property (p_cpu) else $error("cpu access wrong");
	property p_vid; !$past(reset) |-> video_ext_access == !$past(eff[5]); endproperty
	a_vid: assert property (p_vid) else $error("video access wrong");
	property p_st; !$past(reset) |-> selftest_map == $past(!eff[7] && eff[0]); endproperty
	a_st: assert property (p_st) else $error("selftest map wrong");
	property p_pulse;
		s_acc(4'hb) ##1 !wr |-> !second_port_control_line_out ##1 second_port_control_line_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse wrong");
	property p_hold; s_acc(4'h9) |=> (!second_port_control_line_out)[*4]; endproperty
	a_hold: assert property (p_hold) else $error("handshake low wrong");
	property p_fix;
		ctl_q[5:4] == 2'h3 && $past(ctl_q, 2) == ctl_q
			|-> second_port_control_line_oe && second_port_control_line_out == ctl_q[3];
	endproperty
	a_fix: assert property (p_fix) else $error("steady level wrong");
	property p_in; !ctl_q[5] && $past(ctl_q, 2) == ctl_q |-> !second_port_control_line_oe;
	endproperty
	a_in: assert property (p_in) else $error("input mode drives");
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        rd_d;
	logic [7:0]  rdata, a_in, a_out, a_oe, b_in, b_out, b_oe, a_drv, b_drv, v, n;
	logic        a_edge, b_edge, ca_in, ca_out, ca_oe, cb_in, cb_out, cb_oe, ca_drv, cb_drv;
	logic [1:0]  bank;
	logic        cpu, vid, st, irq;
	logic [31:0] seed;
	logic [7:0]  exp_q[$];
	int          error_cnt = 0;
	int          samples_checked = 0;
	ppc_top dut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
		.first_port_data_in(a_in), .first_port_data_out(a_out), .first_port_data_oe(a_oe),
		.second_port_data_in(b_in), .second_port_data_out(b_out), .second_port_data_oe(b_oe),
		.first_port_edge_line(a_edge), .second_port_edge_line(b_edge),
		.first_port_control_line_in(ca_in), .first_port_control_line_out(ca_out),
		.first_port_control_line_oe(ca_oe), .second_port_control_line_in(cb_in),
		.second_port_control_line_out(cb_out), .second_port_control_line_oe(cb_oe),
		.ext_bank_sel(bank), .cpu_ext_access(cpu), .video_ext_access(vid),
		.selftest_map(st), .irq);
	ppc_far far (.a_out, .a_oe, .b_out, .b_oe, .ca_out, .ca_oe, .cb_out, .cb_oe, .a_drv,
		.b_drv, .ca_drv, .cb_drv, .a_pin(a_in), .b_pin(b_in), .ca_pin(ca_in), .cb_pin(cb_in));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_t(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
	endtask
	task automatic rd_t(logic [15:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		exp_q.push_back(e);
	endtask
	task automatic idle(int k);
		repeat (k) begin
			@(posedge clk);
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d === 1'b1) begin
			chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	initial begin
		{addr, wdata, wr, rd, a_drv, b_drv, a_edge, ca_drv, cb_drv} = '0;
		b_edge = 1'b1;
		seed = 32'h4b4a;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_t(ppc_pkg::ADDR_FIRST_CTL, 8'h00);
		rd_t(ppc_pkg::ADDR_FIRST_DATA, ppc_pkg::RST_DDR);
		rd_t(16'hd3f0, ppc_pkg::READ_UNMAPPED);
		wr_t(ppc_pkg::ADDR_SECOND_DATA, 8'hff);
		rd_t(ppc_pkg::ADDR_SECOND_DATA, 8'hff);
		wr_t(ppc_pkg::ADDR_SECOND_CTL, 8'hc4);
		rd_t(ppc_pkg::ADDR_SECOND_CTL, 8'h04);
		repeat (8) begin
			repeat (8) seed = lfsr(seed);
			v = seed[7:0];
			wr_t(ppc_pkg::ADDR_SECOND_DATA, v);
			idle(3);
			chk("bank", {6'h0, v[3:2]}, {6'h0, bank});
			chk("cpu", {7'h0, ~v[4]}, {7'h0, cpu});
			chk("video", {7'h0, ~v[5]}, {7'h0, vid});
			chk("selftest", {7'h0, ~v[7] & v[0]}, {7'h0, st});
			chk("b_out", v, b_out);
			wr_t(ppc_pkg::ADDR_FIRST_DATA, v);
			rd_t(ppc_pkg::ADDR_FIRST_DATA, v);
		end
		wr_t(ppc_pkg::ADDR_FIRST_DATA, 8'h00);
		wr_t(ppc_pkg::ADDR_FIRST_CTL, 8'h07);
		wr_t(ppc_pkg::ADDR_IRQ_ENABLE, 8'h0f);
		a_drv <= seed[15:8];
		idle(8);
		rd_t(ppc_pkg::ADDR_FIRST_DATA, seed[15:8]);
		a_edge <= 1'b1;
		idle(8);
		rd_t(ppc_pkg::ADDR_FIRST_CTL, 8'h87);
		idle(2);
		chk("irq", 8'h01, {7'h0, irq});
		rd_t(ppc_pkg::ADDR_FIRST_DATA, seed[15:8]);
		idle(3);
		chk("irq", 8'h00, {7'h0, irq});
		wr_t(ppc_pkg::ADDR_FIRST_CTL, 8'h04);
		a_edge <= 1'b0;
		idle(8);
		rd_t(ppc_pkg::ADDR_IRQ_STATUS, 8'h01);
		idle(2);
		chk("irq", 8'h00, {7'h0, irq});
		wr_t(ppc_pkg::ADDR_IRQ_CLEAR, 8'h0f);
		wr_t(ppc_pkg::ADDR_SECOND_CTL, 8'h1c);
		rd_t(ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		cb_drv <= 1'b1;
		idle(8);
		rd_t(ppc_pkg::ADDR_SECOND_CTL, 8'h5c);
		idle(2);
		chk("irq", 8'h01, {7'h0, irq});
		wr_t(ppc_pkg::ADDR_SECOND_CTL, 8'h2c);
		idle(2);
		wr_t(ppc_pkg::ADDR_SECOND_DATA, v);
		n = 8'h00;
		repeat (6) begin
			idle(1);
			#1 n = n + {7'h0, cb_out === 1'b0};
		end
		chk("pulse", 8'h01, n);
		wr_t(ppc_pkg::ADDR_SECOND_CTL, 8'h24);
		idle(2);
		wr_t(ppc_pkg::ADDR_SECOND_DATA, v);
		idle(4);
		chk("hold", 8'h00, {7'h0, cb_out});
		b_edge <= 1'b0;
		idle(10);
		chk("release", 8'h01, {7'h0, cb_out});
		for (int m = 6; m < 8; m++) begin
			wr_t(ppc_pkg::ADDR_SECOND_CTL, {2'h0, m[2:0], 3'h4});
			idle(3);
			chk("level", {6'h0, m[0], 1'b1}, {6'h0, cb_out, cb_oe});
		end
		// Port A pulses its control line on a data read, never on a data write.
		wr_t(ppc_pkg::ADDR_FIRST_CTL, 8'h2c);
		wr_t(ppc_pkg::ADDR_FIRST_DATA, 8'h5a);
		idle(2);
		chk("a_out", 8'h5a, a_out);
		chk("a_oe", 8'h00, a_oe);
		chk("ca_write", 8'h03, {6'h0, ca_out, ca_oe});
		rd_t(ppc_pkg::ADDR_FIRST_DATA, seed[15:8]);
		idle(1);
		#1 chk("ca_pulse", 8'h01, {6'h0, ca_out, ca_oe});
		idle(1);
		#1 chk("ca_end", 8'h03, {6'h0, ca_out, ca_oe});
		// A reset in mid-run must clear direction and output registers again.
		idle(1);
		reset <= 1'b1;
		idle(2);
		chk("rst_a", 8'h00, a_out | a_oe);
		chk("rst_b", 8'h00, b_out | b_oe);
		chk("rst_ca", 8'h02, {6'h0, ca_out, ca_oe});
		reset <= 1'b0;
		rd_t(ppc_pkg::ADDR_SECOND_CTL, 8'h00);
		rd_t(ppc_pkg::ADDR_SECOND_DATA, ppc_pkg::RST_DDR);
		idle(2);
		complete_run();
	end
endmodule
bind ppc_top ppc_chk u_chk (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
	.second_port_data_out, .second_port_data_oe, .second_port_control_line_out,
	.second_port_control_line_oe, .ext_bank_sel, .cpu_ext_access, .video_ext_access,
	.selftest_map);
